// >>> rtl/spaa_consts.svh
// Constants for the scan port access arbiter: command word fields,
// operation codes and special configuration port addresses.
// Assumes inclusion by bare name from the rtl directory.
`ifndef SPAA_CONSTS_SVH
`define SPAA_CONSTS_SVH

// Command word layout
`define SPAA_CMD_W 32
`define SPAA_DATA_MSB 15
`define SPAA_DATA_LSB 0
`define SPAA_ADDR_MSB 25
`define SPAA_ADDR_LSB 16
`define SPAA_OP_MSB 29
`define SPAA_OP_LSB 26

// Operation codes
`define SPAA_OP_NOP 4'h0
`define SPAA_OP_READ 4'h1
`define SPAA_OP_WRITE 4'h2

// Special addresses and values
`define SPAA_LOCK_ADDR 10'h000
`define SPAA_AUX_ADDR 10'h002
`define SPAA_VAL_ONE 16'h0001
`define SPAA_VAL_ZERO 16'h0000
`define SPAA_UPPER_ZERO 16'h0000

`endif

// >>> rtl/spaa_pkg.sv
// Types shared by the scan port access arbiter files.
// Assumes nothing of its surroundings.
`default_nettype none

package spaa_pkg;
  // Arbiter states
  typedef enum logic [1:0] {
    SPAA_IDLE = 2'b00,
    SPAA_FAB = 2'b01,
    SPAA_SCAN = 2'b10
  } spaa_state_type;
  typedef logic [9:0] spaa_addr_type;
  typedef logic [15:0] spaa_data_type;
endpackage

`default_nettype wire

// >>> rtl/spaa_scan_dr.sv
// Scan data register on the test clock: capture, shift, update.
// Assumes an outside TAP controller gives one-cycle state strobes on TCK.
`default_nettype none
`include "spaa_consts.svh"

module spaa_scan_dr
  import spaa_pkg::*;
(
  input wire logic tck_i,
  input wire logic tck_resetn_i,
  input wire logic scan_sel_i,
  input wire logic capture_dr_i,
  input wire logic shift_dr_i,
  input wire logic update_dr_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic [`SPAA_CMD_W-1:0] cmd_o,
  output logic cmd_tgl_o,
  input wire logic [15:0] held_i,
  input wire logic held_tgl_i
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [`SPAA_CMD_W-1:0] sr_r, sr_nxt; // Shift register
  logic [`SPAA_CMD_W-1:0] cmd_r, cmd_nxt; // Command handed over
  logic tgl_r, tgl_nxt; // Command event toggle
  logic hs1_r, hs2_r, hs3_r; // Held data toggle sync
  spaa_data_type held_r, held_nxt; // Local copy of held data

  // Next values of the scan side
  always_comb begin
    sr_nxt = sr_r;
    cmd_nxt = cmd_r;
    tgl_nxt = tgl_r;
    held_nxt = held_r;
    // Held word is stable once its toggle has settled
    if (hs2_r != hs3_r) begin
      held_nxt = held_i;
    end
    if (scan_sel_i && capture_dr_i) begin
      sr_nxt = {`SPAA_UPPER_ZERO, held_r};
    end else if (scan_sel_i && shift_dr_i) begin
      sr_nxt = {tdi_i, sr_r[`SPAA_CMD_W-1:1]};
    end else if (scan_sel_i && update_dr_i) begin
      cmd_nxt = sr_r;
      tgl_nxt = ~tgl_r;
    end
  end

  // Registers of the scan side
  always_ff @(posedge tck_i) begin
    if (!tck_resetn_i) begin
      sr_r <= '0;
      cmd_r <= '0;
      tgl_r <= 1'b0;
      hs1_r <= 1'b0;
      hs2_r <= 1'b0;
      hs3_r <= 1'b0;
      held_r <= '0;
    end else begin
      sr_r <= sr_nxt;
      cmd_r <= cmd_nxt;
      tgl_r <= tgl_nxt;
      hs1_r <= held_tgl_i;
      hs2_r <= hs1_r;
      hs3_r <= hs2_r;
      held_r <= held_nxt;
    end
  end

  assign tdo_o = sr_r[0];
  assign cmd_o = cmd_r;
  assign cmd_tgl_o = tgl_r;

  // Capture loads zero upper half
  property p_cap_upper;
    @(posedge tck_i) disable iff (!tck_resetn_i)
    scan_sel_i && capture_dr_i |=> sr_r[31:16] == `SPAA_UPPER_ZERO;
  endproperty
  a_cap_upper: assert property (p_cap_upper) else $error("capture upper not zero");
endmodule

`default_nettype wire

// >>> rtl/spaa_arbiter.sv
// Scan port access arbiter: shares the configuration port between
// fabric logic and a scan tester, one transaction at a time.
// Assumes a port slave on sys_clk_i answering each enable with cp_rdy_i.
`default_nettype none
`include "spaa_consts.svh"

module spaa_arbiter
  import spaa_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic tck_i,
  input wire logic tck_resetn_i,
  input wire logic scan_sel_i,
  input wire logic capture_dr_i,
  input wire logic shift_dr_i,
  input wire logic update_dr_i,
  input wire logic tdi_i,
  output logic tdo_o,
  input wire logic configured_i,
  input wire logic fab_req_i,
  input wire logic fab_we_i,
  input wire logic [9:0] fab_addr_i,
  input wire logic [15:0] fab_di_i,
  output logic [15:0] fab_do_o,
  output logic fab_done_o,
  output logic fab_refused_o,
  output logic cp_en_o,
  output logic cp_we_o,
  output logic [9:0] cp_addr_o,
  output logic [15:0] cp_di_o,
  input wire logic [15:0] cp_do_i,
  input wire logic cp_rdy_i,
  output logic scan_busy_o,
  output logic scan_modified_o,
  output logic scan_lock_o,
  output logic aux_en_o
);
  // ----------------------------------------
  // Scan side and crossing
  // ----------------------------------------
  logic [`SPAA_CMD_W-1:0] cmd_w; // Command word, stable between toggles
  logic cmd_tgl_w; // Command event toggle on TCK
  logic ct1_r, ct2_r, ct3_r; // Toggle synchroniser and edge stage
  logic cf1_r, cf2_r; // Configured pin synchroniser
  spaa_data_type held_r, held_nxt; // Data offered at next capture
  logic held_tgl_r, held_tgl_nxt; // Held data event toggle

  spaa_scan_dr u_scan_dr (
    .tck_i(tck_i),
    .tck_resetn_i(tck_resetn_i),
    .scan_sel_i(scan_sel_i),
    .capture_dr_i(capture_dr_i),
    .shift_dr_i(shift_dr_i),
    .update_dr_i(update_dr_i),
    .tdi_i(tdi_i),
    .tdo_o(tdo_o),
    .cmd_o(cmd_w),
    .cmd_tgl_o(cmd_tgl_w),
    .held_i(held_r),
    .held_tgl_i(held_tgl_r)
  );

  // Command field decode
  logic [3:0] op_w; // Operation field
  spaa_addr_type scan_addr_w; // Target address
  spaa_data_type scan_data_w; // Write data
  logic scan_evt_w; // New command seen on this clock
  logic scan_arr_w; // New read or write command
  assign op_w = cmd_w[`SPAA_OP_MSB:`SPAA_OP_LSB];
  assign scan_addr_w = cmd_w[`SPAA_ADDR_MSB:`SPAA_ADDR_LSB];
  assign scan_data_w = cmd_w[`SPAA_DATA_MSB:`SPAA_DATA_LSB];
  assign scan_evt_w = ct2_r ^ ct3_r;
  // Only read and write start work; other codes are dropped
  assign scan_arr_w = scan_evt_w &&
    (op_w == `SPAA_OP_READ || op_w == `SPAA_OP_WRITE);

  // ----------------------------------------
  // Arbiter state
  // ----------------------------------------
  spaa_state_type state_r, state_nxt; // Port owner
  logic fab_pend_r, fab_pend_nxt; // Fabric request waiting
  logic fab_we_r, fab_we_nxt; // Queued fabric direction
  spaa_addr_type fab_addr_r, fab_addr_nxt; // Queued fabric address
  spaa_data_type fab_di_r, fab_di_nxt; // Queued fabric data
  logic scan_pend_r, scan_pend_nxt; // Scan request waiting
  logic scan_we_r, scan_we_nxt; // Queued scan direction
  spaa_addr_type scan_addr_r, scan_addr_nxt; // Queued scan address
  spaa_data_type scan_di_r, scan_di_nxt; // Queued scan data
  logic cp_en_r, cp_en_nxt; // Port enable pulse
  logic cp_we_r, cp_we_nxt; // Port write select
  spaa_addr_type cp_addr_r, cp_addr_nxt; // Port address
  spaa_data_type cp_di_r, cp_di_nxt; // Port write data
  spaa_data_type fab_do_r, fab_do_nxt; // Fabric read data
  logic fab_done_r, fab_done_nxt; // Fabric done pulse
  logic fab_ref_r, fab_ref_nxt; // Fabric refused pulse
  logic busy_r, busy_nxt; // Scan busy flag
  logic mod_r, mod_nxt; // Scan modified flag
  logic lock_r, lock_nxt; // Scan lock flag
  logic aux_r, aux_nxt; // Auxiliary input enable

  // Next state of the arbiter
  always_comb begin
    state_nxt = state_r;
    fab_pend_nxt = fab_pend_r;
    fab_we_nxt = fab_we_r;
    fab_addr_nxt = fab_addr_r;
    fab_di_nxt = fab_di_r;
    scan_pend_nxt = scan_pend_r;
    scan_we_nxt = scan_we_r;
    scan_addr_nxt = scan_addr_r;
    scan_di_nxt = scan_di_r;
    cp_en_nxt = 1'b0;
    cp_we_nxt = cp_we_r;
    cp_addr_nxt = cp_addr_r;
    cp_di_nxt = cp_di_r;
    fab_do_nxt = fab_do_r;
    fab_done_nxt = 1'b0;
    fab_ref_nxt = 1'b0;
    held_nxt = held_r;
    held_tgl_nxt = held_tgl_r;
    mod_nxt = mod_r;
    lock_nxt = lock_r;
    aux_nxt = aux_r;
    unique case (state_r)
      SPAA_IDLE: begin
        // Fabric wins a tie with the scan side
        if (fab_pend_r) begin
          fab_pend_nxt = 1'b0;
          if (lock_r) begin
            // Locked: answer at once without touching the port
            fab_done_nxt = 1'b1;
            fab_ref_nxt = 1'b1;
            fab_do_nxt = `SPAA_VAL_ZERO;
          end else begin
            state_nxt = SPAA_FAB;
            cp_en_nxt = 1'b1;
            cp_we_nxt = fab_we_r;
            cp_addr_nxt = fab_addr_r;
            cp_di_nxt = fab_di_r;
          end
        end else if (scan_pend_r) begin
          scan_pend_nxt = 1'b0;
          state_nxt = SPAA_SCAN;
          cp_en_nxt = 1'b1;
          cp_we_nxt = scan_we_r;
          cp_addr_nxt = scan_addr_r;
          cp_di_nxt = scan_di_r;
        end
      end
      SPAA_FAB: begin
        // Fabric access runs to its end even if scan waits
        if (cp_rdy_i) begin
          state_nxt = SPAA_IDLE;
          fab_done_nxt = 1'b1;
          fab_do_nxt = cp_do_i;
          mod_nxt = 1'b0;
        end
      end
      SPAA_SCAN: begin
        if (cp_rdy_i) begin
          state_nxt = SPAA_IDLE;
          // Read result or written data waits for next capture
          held_nxt = cp_we_r ? cp_di_r : cp_do_i;
          held_tgl_nxt = ~held_tgl_r;
          mod_nxt = cp_we_r;
          if (cp_we_r && cp_addr_r == `SPAA_LOCK_ADDR) begin
            if (cp_di_r == `SPAA_VAL_ONE) begin
              lock_nxt = 1'b1;
            end else if (cp_di_r == `SPAA_VAL_ZERO) begin
              lock_nxt = 1'b0;
            end
          end
          if (cp_we_r && cp_addr_r == `SPAA_AUX_ADDR && cp_di_r == `SPAA_VAL_ONE) begin
            aux_nxt = 1'b1;
          end
        end
      end
      default: state_nxt = SPAA_IDLE;
    endcase
    // New requests are taken after the grant so a set is never lost
    if (fab_req_i) begin
      fab_pend_nxt = 1'b1;
      fab_we_nxt = fab_we_i;
      fab_addr_nxt = fab_addr_i;
      fab_di_nxt = fab_di_i;
    end
    if (scan_arr_w) begin
      scan_pend_nxt = 1'b1;
      scan_we_nxt = (op_w == `SPAA_OP_WRITE);
      scan_addr_nxt = scan_addr_w;
      scan_di_nxt = scan_data_w;
    end
    // After configuration the aux enable has no effect
    if (cf2_r) begin
      aux_nxt = 1'b0;
    end
    // Busy spans waiting and running scan work
    busy_nxt = scan_pend_nxt || state_nxt == SPAA_SCAN;
  end

  // Registers of the arbiter
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      {ct1_r, ct2_r, ct3_r, cf1_r, cf2_r} <= '0;
      state_r <= SPAA_IDLE;
      {fab_pend_r, fab_we_r, fab_addr_r, fab_di_r} <= '0;
      {scan_pend_r, scan_we_r, scan_addr_r, scan_di_r} <= '0;
      {cp_en_r, cp_we_r, cp_addr_r, cp_di_r} <= '0;
      {fab_do_r, fab_done_r, fab_ref_r} <= '0;
      {held_r, held_tgl_r} <= '0;
      {busy_r, mod_r, lock_r, aux_r} <= '0;
    end else begin
      ct1_r <= cmd_tgl_w;
      ct2_r <= ct1_r;
      ct3_r <= ct2_r;
      cf1_r <= configured_i;
      cf2_r <= cf1_r;
      state_r <= state_nxt;
      fab_pend_r <= fab_pend_nxt;
      fab_we_r <= fab_we_nxt;
      fab_addr_r <= fab_addr_nxt;
      fab_di_r <= fab_di_nxt;
      scan_pend_r <= scan_pend_nxt;
      scan_we_r <= scan_we_nxt;
      scan_addr_r <= scan_addr_nxt;
      scan_di_r <= scan_di_nxt;
      cp_en_r <= cp_en_nxt;
      cp_we_r <= cp_we_nxt;
      cp_addr_r <= cp_addr_nxt;
      cp_di_r <= cp_di_nxt;
      fab_do_r <= fab_do_nxt;
      fab_done_r <= fab_done_nxt;
      fab_ref_r <= fab_ref_nxt;
      held_r <= held_nxt;
      held_tgl_r <= held_tgl_nxt;
      busy_r <= busy_nxt;
      mod_r <= mod_nxt;
      lock_r <= lock_nxt;
      aux_r <= aux_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cp_en_o = cp_en_r;
  assign cp_we_o = cp_we_r;
  assign cp_addr_o = cp_addr_r;
  assign cp_di_o = cp_di_r;
  assign fab_do_o = fab_do_r;
  assign fab_done_o = fab_done_r;
  assign fab_refused_o = fab_ref_r;
  assign scan_busy_o = busy_r;
  assign scan_modified_o = mod_r;
  assign scan_lock_o = lock_r;
  assign aux_en_o = aux_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_busy_rise;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    scan_arr_w |=> scan_busy_o;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");
  property p_nop;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    scan_evt_w && op_w == `SPAA_OP_NOP && !scan_pend_r && state_r != SPAA_SCAN
      |=> !scan_busy_o && $stable(held_r);
  endproperty
  a_nop: assert property (p_nop) else $error("no-op started work");
  property p_single;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    cp_en_o |-> state_r != SPAA_IDLE ##1 !cp_en_o;
  endproperty
  a_single: assert property (p_single) else $error("overlapping port access");
  property p_refuse;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    state_r == SPAA_IDLE && fab_pend_r && scan_lock_o |=> fab_refused_o && !cp_en_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("locked fabric access ran");
  property p_fab_first;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    state_r == SPAA_IDLE && fab_pend_r && scan_pend_r && !scan_lock_o
      |=> state_r == SPAA_FAB;
  endproperty
  a_fab_first: assert property (p_fab_first) else $error("scan beat fabric on tie");
  property p_scan_hold;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    state_r == SPAA_SCAN |-> !fab_done_o;
  endproperty
  a_scan_hold: assert property (p_scan_hold) else $error("fabric done during scan");
  property p_fab_keep;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    state_r == SPAA_FAB && !cp_rdy_i |=> state_r == SPAA_FAB;
  endproperty
  a_fab_keep: assert property (p_fab_keep) else $error("fabric access interrupted");
  property p_mod;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    state_r == SPAA_SCAN && cp_rdy_i && cp_we_o |=> scan_modified_o;
  endproperty
  a_mod: assert property (p_mod) else $error("modified not set");
  property p_lock;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    state_r == SPAA_SCAN && cp_rdy_i && cp_we_o && cp_addr_o == `SPAA_LOCK_ADDR
      && cp_di_o == `SPAA_VAL_ONE |=> scan_lock_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not set");
  property p_aux;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    cf2_r |=> !aux_en_o;
  endproperty
  a_aux: assert property (p_aux) else $error("aux enabled after configuration");
endmodule

`default_nettype wire

// >>> dv/spaa_port_slave.sv
// Port slave model: a configuration port register file that answers each
// enable with a ready pulse after lat_i extra cycles.
// Assumes the arbiter launches enables just after rising edges of clk_i.
`default_nettype none

module spaa_port_slave
  import spaa_pkg::*;
(
  input wire logic clk_i,
  input wire logic cp_en_i,
  input wire logic cp_we_i,
  input wire spaa_addr_type cp_addr_i,
  input wire spaa_data_type cp_di_i,
  input wire logic [7:0] lat_i,
  output logic [15:0] cp_do_o,
  output logic cp_rdy_o
);
  timeunit 1ns;
  timeprecision 100ps;

  spaa_data_type mem [1024]; // Register contents
  spaa_addr_type addr_r; // Address of the open access
  logic open_r; // Access waiting for its answer
  logic [7:0] cnt_r; // Remaining wait cycles

  // Preset contents so that every address reads a known value
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 16'hC000 ^ 16'(i);
    end
    cp_do_o = 16'h0000;
    cp_rdy_o = 1'b0;
    open_r = 1'b0;
    cnt_r = 8'h00;
    addr_r = 10'h000;
  end

  // Take an enable, wait, answer; read data toggles while not valid
  always @(posedge clk_i) begin
    cp_rdy_o <= 1'b0;
    cp_do_o <= ~cp_do_o;
    if (cp_en_i) begin
      open_r <= 1'b1;
      cnt_r <= lat_i;
      addr_r <= cp_addr_i;
      if (cp_we_i) begin
        mem[cp_addr_i] <= cp_di_i;
      end
    end else if (open_r && cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else if (open_r) begin
      cp_rdy_o <= 1'b1;
      cp_do_o <= mem[addr_r];
      open_r <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// >>> dv/testbench.sv
// Testbench for the scan port access arbiter: scan tester, fabric master
// and port slave model around one arbiter.
// Assumes the rtl package and the constants header on the include path.
`default_nettype none
`include "spaa_consts.svh"

module testbench
  import spaa_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk_i, resetn_i, tck_i, tck_resetn_i, scan_sel_i, tdi_i, tdo_o;
  logic capture_dr_i, shift_dr_i, update_dr_i, configured_i;
  logic fab_req_i, fab_we_i, fab_done_o, fab_refused_o, cp_en_o, cp_we_o, cp_rdy_i;
  logic scan_busy_o, scan_modified_o, scan_lock_o, aux_en_o;
  spaa_addr_type fab_addr_i, cp_addr_o;
  spaa_data_type fab_di_i, fab_do_o, cp_di_o, cp_do_i, q;
  logic [7:0] lat; // Slave answer delay
  logic tck_run, open_r, busy_seen, rf; // Monitor and tester state
  logic [31:0] cap; // Word captured out of the scan register
  int n_errors, comparisons, n_en, n_ovl;

  spaa_arbiter dut (.sys_clk_i, .resetn_i, .tck_i, .tck_resetn_i, .scan_sel_i,
    .capture_dr_i, .shift_dr_i, .update_dr_i, .tdi_i, .tdo_o, .configured_i,
    .fab_req_i, .fab_we_i, .fab_addr_i, .fab_di_i, .fab_do_o, .fab_done_o,
    .fab_refused_o, .cp_en_o, .cp_we_o, .cp_addr_o, .cp_di_o, .cp_do_i, .cp_rdy_i,
    .scan_busy_o, .scan_modified_o, .scan_lock_o, .aux_en_o);

  spaa_port_slave slave (.clk_i(sys_clk_i), .cp_en_i(cp_en_o), .cp_we_i(cp_we_o),
    .cp_addr_i(cp_addr_o), .cp_di_i(cp_di_o), .lat_i(lat), .cp_do_o(cp_do_i),
    .cp_rdy_o(cp_rdy_i));

  // ----------------------------------------------------------------
  // Clocks and port monitor
  // ----------------------------------------------------------------
  always #2.5 sys_clk_i = ~sys_clk_i;

  // Test clock runs only during the TCK reset and while a frame is in flight, stopping low
  initial begin
    #7.3;
    forever begin
      #15;
      if (tck_run || tck_i) tck_i = ~tck_i;
    end
  end

  // Count enables and overlapping enables; flag any sighting of scan busy
  always @(posedge sys_clk_i) begin
    if (cp_rdy_i === 1'b1) open_r = 1'b0;
    if (cp_en_o === 1'b1 && open_r) n_ovl++;
    if (cp_en_o === 1'b1) open_r = 1'b1;
    if (cp_en_o === 1'b1) n_en++;
    if (scan_busy_o === 1'b1) busy_seen = 1'b1;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    stop_test();
  endtask

  task automatic chk16(input spaa_data_type got, input spaa_data_type exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic tk();
    @(posedge sys_clk_i);
    #1;
  endtask

  function automatic logic [31:0] mk(input logic [3:0] op, input spaa_addr_type a,
                                     input spaa_data_type d);
    return {2'b00, op, a, d};
  endfunction

  // One data scan: capture, shift 32 bits LSB first, update, then idle
  task automatic scan(input logic [31:0] w, output logic [31:0] c);
    tck_run = 1'b1;
    repeat (4) @(posedge tck_i);
    #1 capture_dr_i = 1'b1;
    @(posedge tck_i);
    #1 capture_dr_i = 1'b0;
    for (int i = 0; i < 32; i++) begin
      shift_dr_i = 1'b1;
      tdi_i = w[i];
      c[i] = tdo_o;
      @(posedge tck_i);
      #1;
    end
    shift_dr_i = 1'b0;
    tdi_i = ~w[31];
    update_dr_i = 1'b1;
    @(posedge tck_i);
    #1 update_dr_i = 1'b0;
    repeat (12) @(posedge tck_i);
    tck_run = 1'b0;
    tk();
  endtask

  // Wait until the scan side and the port are quiet
  task automatic settle();
    int i;
    for (i = 0; i < 400 && (scan_busy_o !== 1'b0 || open_r); i++) tk();
    if (i == 400) hang();
    repeat (3) tk();
  endtask

  task automatic fab(input logic we, input spaa_addr_type a, input spaa_data_type d,
                     output spaa_data_type rd, output logic refused);
    int i;
    fab_req_i = 1'b1;
    fab_we_i = we;
    fab_addr_i = a;
    fab_di_i = d;
    tk();
    fab_req_i = 1'b0;
    for (i = 0; i < 400 && fab_done_o !== 1'b1; i++) tk();
    if (i == 400) hang();
    rd = fab_do_o;
    refused = fab_refused_o;
    tk();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_scan_write();
    busy_seen = 1'b0;
    scan(mk(`SPAA_OP_WRITE, 10'h155, 16'hA5C3), cap);
    settle();
    chk16(slave.mem[10'h155], 16'hA5C3);
    chk1(busy_seen, 1'b1);
    chk1(scan_modified_o, 1'b1);
    fab(1'b0, 10'h155, 16'h0000, q, rf);
    chk16(q, 16'hA5C3);
    chk1(scan_modified_o, 1'b0);
  endtask

  // Read, then two empty scans: result shows once and stays put
  task automatic t_scan_read();
    int n0;
    scan(mk(`SPAA_OP_READ, 10'h0AB, 16'hFFFF), cap);
    settle();
    n0 = n_en;
    busy_seen = 1'b0;
    scan(mk(`SPAA_OP_NOP, 10'h0AB, 16'h0000), cap);
    chk16(cap[31:16], 16'h0000);
    chk16(cap[15:0], 16'hC0AB);
    // A write scanned while another instruction is loaded must do nothing
    scan_sel_i = 1'b0;
    scan(mk(`SPAA_OP_WRITE, 10'h0AB, 16'h1234), cap);
    scan_sel_i = 1'b1;
    scan(mk(`SPAA_OP_NOP, 10'h3FF, 16'h1234), cap);
    settle();
    chk16(cap[15:0], 16'hC0AB);
    chk16(slave.mem[10'h0AB], 16'hC0AB);
    chk16(16'(n_en - n0), 16'h0000);
    chk1(busy_seen, 1'b0);
  endtask

  task automatic t_lock();
    scan(mk(`SPAA_OP_WRITE, `SPAA_LOCK_ADDR, `SPAA_VAL_ONE), cap);
    settle();
    chk1(scan_lock_o, 1'b1);
    fab(1'b1, 10'h033, 16'h1111, q, rf);
    chk1(rf, 1'b1);
    chk16(q, 16'h0000);
    chk16(slave.mem[10'h033], 16'hC033);
    scan(mk(`SPAA_OP_WRITE, `SPAA_LOCK_ADDR, `SPAA_VAL_ZERO), cap);
    settle();
    chk1(scan_lock_o, 1'b0);
    fab(1'b1, 10'h033, 16'h1111, q, rf);
    chk1(rf, 1'b0);
    chk16(slave.mem[10'h033], 16'h1111);
  endtask

  task automatic t_aux();
    scan(mk(`SPAA_OP_WRITE, `SPAA_AUX_ADDR, `SPAA_VAL_ONE), cap);
    settle();
    chk1(aux_en_o, 1'b1);
    configured_i = 1'b1;
    repeat (4) tk();
    chk1(aux_en_o, 1'b0);
    scan(mk(`SPAA_OP_WRITE, `SPAA_AUX_ADDR, `SPAA_VAL_ONE), cap);
    settle();
    chk1(aux_en_o, 1'b0);
  endtask

  // Fabric access running with a slow slave when the scan write lands
  task automatic t_fab_first();
    int i;
    lat = 8'h14;
    fork
      scan(mk(`SPAA_OP_WRITE, 10'h011, 16'h2222), cap);
      begin
        for (i = 0; i < 2000 && update_dr_i !== 1'b1; i++) tk();
        if (i == 2000) hang();
        fab(1'b1, 10'h011, 16'h1111, q, rf);
      end
    join
    settle();
    chk16(slave.mem[10'h011], 16'h2222);
  endtask

  // Fabric write issued while a slow scan write is busy
  task automatic t_scan_first();
    int i;
    fork
      scan(mk(`SPAA_OP_WRITE, 10'h022, 16'h3333), cap);
      begin
        for (i = 0; i < 2000 && scan_busy_o !== 1'b1; i++) tk();
        if (i == 2000) hang();
        fab(1'b1, 10'h022, 16'h4444, q, rf);
        chk1(scan_busy_o, 1'b0);
      end
    join
    settle();
    chk16(slave.mem[10'h022], 16'h4444);
    lat = 8'h00;
  endtask

  // Fabric read taken on the same edge as a scan write: fabric goes first
  task automatic t_tie();
    int i;
    fork
      scan(mk(`SPAA_OP_WRITE, 10'h044, 16'h5555), cap);
      begin
        for (i = 0; i < 2000 && dut.ct2_r === dut.ct3_r; i++) tk();
        if (i == 2000) hang();
        fab(1'b0, 10'h044, 16'h0000, q, rf);
      end
    join
    settle();
    chk16(q, 16'hC044);
    chk16(slave.mem[10'h044], 16'h5555);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {sys_clk_i, tck_i, resetn_i, tck_resetn_i, tck_run, open_r, busy_seen} = 7'h00;
    {capture_dr_i, shift_dr_i, update_dr_i, tdi_i, configured_i} = 5'h00;
    {fab_req_i, fab_we_i, fab_addr_i, fab_di_i} = 28'h0000000;
    scan_sel_i = 1'b1;
    lat = 8'h00;
    n_errors = 0;
    comparisons = 0;
    n_en = 0;
    n_ovl = 0;
    repeat (6) @(posedge sys_clk_i);
    #1 resetn_i = 1'b1;
    tck_run = 1'b1;
    repeat (5) @(posedge tck_i);
    #1 tck_resetn_i = 1'b1;
    tck_run = 1'b0;
    tk();
    chk1(scan_busy_o, 1'b0);
    chk1(scan_lock_o, 1'b0);
    t_scan_write();
    t_scan_read();
    t_lock();
    t_aux();
    t_fab_first();
    t_scan_first();
    t_tie();
    chk16(16'(n_ovl), 16'h0000);
    stop_test();
  end
endmodule

`default_nettype wire
